// file: core/shk_defs.svh
// register offsets, field positions, reset values and timing counts of the socket housekeeping block
`ifndef SHK_DEFS_SVH
`define SHK_DEFS_SVH
// register byte offsets
`define SHK_ADR_EVENT_FLAGS 8'h00
`define SHK_ADR_EVENT_MASK 8'h04
`define SHK_ADR_PRESENT 8'h08
`define SHK_ADR_EVENT_FORCE 8'h0c
`define SHK_ADR_POWER_CTRL 8'h10
`define SHK_ADR_RSVD_FIRST 8'h14
`define SHK_ADR_RSVD_LAST 8'h1c
`define SHK_ADR_POWER_MGMT 8'h20
`define SHK_ADR_GENERAL_CTRL 8'h24
`define SHK_ADR_CARD_CTRL 8'h28
// field positions
`define SHK_BIT_SWITCH_TYPE 10
`define SHK_BIT_SPK_EN 1
`define SHK_BIT_PWM_ROUTE 2
`define SHK_CARD_CTRL_STRIDE 8
// reset values
`define SHK_RST_EVENT_MASK 2'h3
`define SHK_RST_POWER_CTRL 13'h0000
`define SHK_RST_GENERAL_CTRL 1'h0
`define SHK_RST_CARD_CTRL 4'h0
// timing: clock rate, oscillator rate, filter and indicator times
`define SHK_CLK_HZ 25000000
`define SHK_OSC_HZ 16000
`define SHK_DEBOUNCE_MS 50
`define SHK_LED_MS 64
`define SHK_TICK_DIV (`SHK_CLK_HZ / `SHK_OSC_HZ)
`define SHK_DEBOUNCE_TICKS ((`SHK_DEBOUNCE_MS * `SHK_OSC_HZ + 999) / 1000)
`define SHK_LED_TICKS ((`SHK_LED_MS * `SHK_OSC_HZ) / 1000)
// power management state codes
`define SHK_PSTATE_D1 2'h1
`define SHK_PSTATE_D2 2'h2
`endif

// file: core/shk_pkg.sv
// types of the socket housekeeping block
package shk_pkg;
    // flash slot detection and power states
    typedef enum logic [1:0] {
        SHK_EMPTY_OFF,
        SHK_INSERTED_OFF,
        SHK_INSERTED_ON
    } shk_slot_state_t;

    // software power request word for the switch and the flash slots
    typedef struct packed {
        logic slot1_power;
        logic slot0_power;
        logic switch_shutdown_n;
        logic [2:0] vpp_b;
        logic [1:0] vcc_b;
        logic [2:0] vpp_a;
        logic [1:0] vcc_a;
    } shk_power_ctrl_t;

    // per-socket audio steering bits
    typedef struct packed {
        logic audio_pwm_route;
        logic speaker_out_enable;
    } shk_audio_ctrl_t;
endpackage

// file: core/shk_socket_housekeeping.sv
// socket detect, switch encoding, status pull select, audio steering and activity indicators
//
// Notes on behaviour
// - slot0 detect low means card present
// - slot1 detect low means card present
// - insertion filtered about fifty milliseconds
// - removal seen at once, feeds slot logic
// - slot states: empty, inserted off, on
// - drive power switch control word, both variants
// - switch type bit ten, reset default variant
// - default variant vpp bits incl 1.8 V
// - alternate variant vpp bits incl 12 V
// - vcc bit pairs, shutdown low floats outputs
// - slow oscillator tick times power and filter
// - status pull up for 16-bit, down CardBus
// - binary audio to speaker when enabled
// - route CardBus pwm audio to separate output
// - indicators active high, A, B, either
// - indicator high sixty-four ms after activity
// - indicate only inserted, powered, out of reset
// - activity from ready low or bus strobes
// - indicators cut in suspend, clock stop, D1/D2
// - new activity restarts the indicator counter
// - low core card sets flag by type
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`include "shk_defs.svh"
module shk_socket_housekeeping
    import shk_pkg::*;
#(
    parameter int TICK_DIV = `SHK_TICK_DIV,
    parameter int DEBOUNCE_TICKS = `SHK_DEBOUNCE_TICKS,
    parameter int LED_TICKS = `SHK_LED_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins from the sockets and the system
    input wire logic flash_slot0_detect_n_i,
    input wire logic flash_slot1_detect_n_i,
    input wire logic [1:0] card_ready_irq_n_i,
    input wire logic [1:0] cb_frame_n_i,
    input wire logic [1:0] cb_irdy_n_i,
    input wire logic [1:0] cb_req_n_i,
    input wire logic [1:0] card_speaker_in_i,
    input wire logic suspend_i,
    input wire logic clkrun_stop_i,
    // from pc card interrogation logic on this clock
    input wire logic [1:0] socket_inserted_i,
    input wire logic [1:0] socket_powered_i,
    input wire logic [1:0] socket_in_reset_i,
    input wire logic [1:0] socket_cardbus_i,
    input wire logic [1:0] socket_low_core_i,
    // outputs
    output logic [10:0] switch_ctrl_o,
    output logic [1:0] flash_slot_power_o,
    output logic [1:0] stschg_pullup_o,
    output logic [1:0] stschg_pulldown_o,
    output logic speaker_out_o,
    output logic audio_pwm_out_o,
    output logic socket_a_activity_led_o,
    output logic socket_b_activity_led_o,
    output logic any_socket_activity_led_o
);
    localparam int SYNC_W = 14;
    localparam int TICK_W = $clog2(TICK_DIV + 1);
    localparam int DB_W = $clog2(DEBOUNCE_TICKS + 1);
    localparam int LED_W = $clog2(LED_TICKS + 1);

    // two-stage synchroniser for every pin input
    logic [SYNC_W-1:0] sync_meta; // first stage, read only by second
    logic [SYNC_W-1:0] sync_pins; // safe copy
    logic [1:0] detect_n; // synchronised card detect pins
    logic [1:0] ready_n;
    logic [1:0] frame_n;
    logic [1:0] irdy_n;
    logic [1:0] req_n;
    logic [1:0] audio_in;
    logic suspend_s;
    logic clkrun_stop_s;

    // slow tick standing in for the free running oscillator
    logic [TICK_W-1:0] tick_cnt;
    logic osc_tick;

    // flash slots
    logic [DB_W-1:0] db_cnt [2];
    logic [1:0] slot_present; // filtered detect, high = card present
    logic [1:0] last_present; // previous, for change events
    shk_slot_state_t slot_state [2];

    // registers
    logic [1:0] event_flags;
    logic [1:0] event_mask;
    shk_power_ctrl_t power_ctrl;
    logic [1:0] power_state;
    logic switch_type_select; // 0 = default variant, 1 = alternate
    shk_audio_ctrl_t [1:0] card_ctrl;
    logic [1:0] voltage_flags; // {other voltage, three volt}

    // indicators
    logic [LED_W-1:0] led_cnt [2];
    logic [LED_W-1:0] next_led_cnt [2];
    logic [1:0] activity;
    logic led_cut;

    // bus decode
    logic bus_req;
    logic bus_wr;
    logic [1:0] force_set;
    logic [1:0] clear_set;
    logic [31:0] next_rdata;
    logic [31:0] wdata; // write data masked by byte selects

    // encodings of the switch control bits
    function automatic logic [2:0] vpp_bits(input logic [2:0] sel, input logic alt);
        logic [2:0] r;
        r = alt ? 3'h6 : 3'h4; // float unless listed
        unique case (sel)
            3'h0: r = 3'h0; // 0 V
            3'h1: r = 3'h2; // 3.3 V
            3'h2: r = 3'h3; // 5 V
            3'h3: r = alt ? 3'h4 : 3'h7; // 12 V or 1.8 V
            default: r = alt ? 3'h6 : 3'h4; // float
        endcase
        return r;
    endfunction

    function automatic logic [1:0] vcc_bits(input logic [1:0] sel);
        logic [1:0] r;
        r = 2'h0;
        unique case (sel)
            2'h1: r = 2'h1; // 3.3 V
            2'h2: r = 2'h2; // 5 V
            default: r = 2'h0; // 0 V
        endcase
        return r;
    endfunction

    // pin synchroniser
    always_ff @(posedge clk_i) begin
        sync_meta <= {flash_slot1_detect_n_i, flash_slot0_detect_n_i, card_ready_irq_n_i, cb_frame_n_i,
                      cb_irdy_n_i, cb_req_n_i, card_speaker_in_i, suspend_i, clkrun_stop_i};
        sync_pins <= sync_meta;
    end

    assign {detect_n, ready_n, frame_n, irdy_n, req_n, audio_in, suspend_s, clkrun_stop_s} = sync_pins;

    // slow tick divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
            osc_tick <= 1'b0;
        end else if (tick_cnt == TICK_W'(TICK_DIV - 1)) begin
            tick_cnt <= '0;
            osc_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            osc_tick <= 1'b0;
        end
    end

    // insertion filter: low must hold for the whole interval
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i) begin
                db_cnt[i] <= '0;
                slot_present[i] <= 1'b0;
            end else if (detect_n[i]) begin
                db_cnt[i] <= '0;
                slot_present[i] <= 1'b0;
            end else if (osc_tick && !slot_present[i]) begin
                if (db_cnt[i] == DB_W'(DEBOUNCE_TICKS - 1)) begin
                    slot_present[i] <= 1'b1;
                end
                db_cnt[i] <= db_cnt[i] + 1'b1;
            end
        end
    end

    // slot detection and power state machines
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i) begin
                slot_state[i] <= SHK_EMPTY_OFF;
            end else if (!slot_present[i]) begin
                slot_state[i] <= SHK_EMPTY_OFF;
            end else if (osc_tick) begin
                unique case (slot_state[i])
                    SHK_EMPTY_OFF: slot_state[i] <= SHK_INSERTED_OFF;
                    SHK_INSERTED_OFF: begin
                        if (i == 0 ? power_ctrl.slot0_power : power_ctrl.slot1_power) begin
                            slot_state[i] <= SHK_INSERTED_ON;
                        end
                    end
                    SHK_INSERTED_ON: begin
                        if (!(i == 0 ? power_ctrl.slot0_power : power_ctrl.slot1_power)) begin
                            slot_state[i] <= SHK_INSERTED_OFF;
                        end
                    end
                    default: slot_state[i] <= SHK_EMPTY_OFF;
                endcase
            end
        end
    end

    // slot power outputs
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i) begin
                flash_slot_power_o[i] <= 1'b0;
            end else begin
                flash_slot_power_o[i] <= (slot_state[i] == SHK_INSERTED_ON) && slot_present[i];
            end
        end
    end

    // switch control word, bit n is switch control bit Dn
    always_ff @(posedge clk_i) begin
        logic [2:0] va;
        logic [2:0] vb;
        logic [1:0] ca;
        logic [1:0] cb;
        va = vpp_bits(power_ctrl.vpp_a, switch_type_select);
        vb = vpp_bits(power_ctrl.vpp_b, switch_type_select);
        ca = vcc_bits(power_ctrl.vcc_a);
        cb = vcc_bits(power_ctrl.vcc_b);
        if (rst_i) begin
            switch_ctrl_o <= 11'h000;
        end else begin
            switch_ctrl_o <= {vb[0], va[0], power_ctrl.switch_shutdown_n, cb[0], cb[1], vb[1], vb[2],
                              ca[1], ca[0], va[1], va[2]};
        end
    end

    // status change pull direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stschg_pullup_o <= 2'h0;
            stschg_pulldown_o <= 2'h0;
        end else begin
            stschg_pullup_o <= socket_inserted_i & ~socket_cardbus_i;
            stschg_pulldown_o <= socket_inserted_i & socket_cardbus_i;
        end
    end

    // audio steering
    always_ff @(posedge clk_i) begin
        logic spk;
        logic pwm;
        spk = 1'b0;
        pwm = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (card_ctrl[i].audio_pwm_route && socket_cardbus_i[i]) begin
                pwm = pwm | audio_in[i];
            end else if (card_ctrl[i].speaker_out_enable) begin
                spk = spk | audio_in[i];
            end
        end
        if (rst_i) begin
            speaker_out_o <= 1'b0;
            audio_pwm_out_o <= 1'b0;
        end else begin
            speaker_out_o <= spk;
            audio_pwm_out_o <= pwm;
        end
    end

    // low core card reporting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            voltage_flags <= 2'h0;
        end else begin
            voltage_flags[0] <= |(socket_low_core_i & socket_cardbus_i) && !switch_type_select;
            voltage_flags[1] <= |(socket_low_core_i & socket_cardbus_i) && switch_type_select;
        end
    end

    // activity detection and indicator counters
    always_comb begin
        led_cut = suspend_s || clkrun_stop_s || power_state == `SHK_PSTATE_D1 ||
                  power_state == `SHK_PSTATE_D2;
        for (int i = 0; i < 2; i++) begin
            activity[i] = socket_cardbus_i[i] ? (!frame_n[i] || !irdy_n[i] || !req_n[i]) : !ready_n[i];
            if (led_cut || !socket_inserted_i[i] || !socket_powered_i[i] || socket_in_reset_i[i]) begin
                next_led_cnt[i] = '0;
            end else if (activity[i]) begin
                next_led_cnt[i] = LED_W'(LED_TICKS);
            end else if (osc_tick && led_cnt[i] != '0) begin
                next_led_cnt[i] = led_cnt[i] - 1'b1;
            end else begin
                next_led_cnt[i] = led_cnt[i];
            end
        end
    end

    // indicator registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_cnt[0] <= '0;
            led_cnt[1] <= '0;
            socket_a_activity_led_o <= 1'b0;
            socket_b_activity_led_o <= 1'b0;
            any_socket_activity_led_o <= 1'b0;
        end else begin
            led_cnt[0] <= next_led_cnt[0];
            led_cnt[1] <= next_led_cnt[1];
            socket_a_activity_led_o <= next_led_cnt[0] != '0;
            socket_b_activity_led_o <= next_led_cnt[1] != '0;
            any_socket_activity_led_o <= next_led_cnt[0] != '0 || next_led_cnt[1] != '0;
        end
    end

    // bus request decode
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i;
    assign wdata = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & wb_dat_i;
    assign force_set = (bus_wr && wb_adr_i == `SHK_ADR_EVENT_FORCE) ? wdata[1:0] : 2'h0;
    assign clear_set = (bus_wr && wb_adr_i == `SHK_ADR_EVENT_FLAGS) ? wdata[1:0] : 2'h0;

    // insertion and removal event flags, a new event beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_present <= 2'h0;
            event_flags <= 2'h0;
        end else begin
            last_present <= slot_present;
            event_flags <= (event_flags & ~clear_set) | force_set |
                           ((slot_present ^ last_present) & event_mask);
        end
    end

    // software writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_mask <= `SHK_RST_EVENT_MASK;
            power_ctrl <= `SHK_RST_POWER_CTRL;
            power_state <= 2'h0;
            switch_type_select <= `SHK_RST_GENERAL_CTRL;
            card_ctrl <= `SHK_RST_CARD_CTRL;
        end else if (bus_wr) begin
            unique case (wb_adr_i)
                `SHK_ADR_EVENT_MASK: event_mask <= wdata[1:0];
                `SHK_ADR_POWER_CTRL: power_ctrl <= wdata[12:0];
                `SHK_ADR_POWER_MGMT: power_state <= wdata[1:0];
                `SHK_ADR_GENERAL_CTRL: switch_type_select <= wdata[`SHK_BIT_SWITCH_TYPE];
                `SHK_ADR_CARD_CTRL: begin
                    card_ctrl[0] <= {wdata[`SHK_BIT_PWM_ROUTE], wdata[`SHK_BIT_SPK_EN]};
                    card_ctrl[1] <= {wdata[`SHK_BIT_PWM_ROUTE + `SHK_CARD_CTRL_STRIDE],
                                     wdata[`SHK_BIT_SPK_EN + `SHK_CARD_CTRL_STRIDE]};
                end
                default: ; // read-only, reserved or unmapped: ignored
            endcase
        end
    end

    // read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            `SHK_ADR_EVENT_FLAGS: next_rdata[1:0] = event_flags;
            `SHK_ADR_EVENT_MASK: next_rdata[1:0] = event_mask;
            `SHK_ADR_PRESENT: next_rdata[11:0] = {socket_b_activity_led_o, socket_a_activity_led_o,
                                                 2'h0, voltage_flags, slot_state[1], slot_state[0],
                                                 slot_present};
            `SHK_ADR_POWER_CTRL: next_rdata[12:0] = power_ctrl;
            `SHK_ADR_POWER_MGMT: next_rdata[1:0] = power_state;
            `SHK_ADR_GENERAL_CTRL: next_rdata[`SHK_BIT_SWITCH_TYPE] = switch_type_select;
            `SHK_ADR_CARD_CTRL: begin
                next_rdata[`SHK_BIT_PWM_ROUTE:`SHK_BIT_SPK_EN] = card_ctrl[0];
                next_rdata[`SHK_BIT_PWM_ROUTE + `SHK_CARD_CTRL_STRIDE:`SHK_BIT_SPK_EN + `SHK_CARD_CTRL_STRIDE] =
                    card_ctrl[1];
            end
            default: next_rdata = 32'h0000_0000; // force, reserved, unmapped read zero
        endcase
    end

    // bus answer: one wait state, ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
        end
    end
endmodule

// file: tb/shk_housekeeping_chk.sv
// port checker of the socket housekeeping block
`timescale 1ns/100ps
module shk_housekeeping_chk #(
    parameter int TICK_DIV = 4,
    parameter int DEBOUNCE_TICKS = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic flash_slot0_detect_n_i,
    input wire logic suspend_i,
    input wire logic [1:0] socket_inserted_i,
    input wire logic [1:0] socket_cardbus_i,
    input wire logic [1:0] flash_slot_power_o,
    input wire logic [1:0] stschg_pullup_o,
    input wire logic [1:0] stschg_pulldown_o,
    input wire logic socket_a_activity_led_o,
    input wire logic any_socket_activity_led_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // cycles the slot0 detect pin has stayed low
    int low_cnt;
    // saturating count, cleared by any high sample
    always_ff @(posedge clk_i) begin
        if (rst_i || flash_slot0_detect_n_i) begin
            low_cnt <= 0;
        end else if (low_cnt < DEBOUNCE_TICKS * TICK_DIV) begin
            low_cnt <= low_cnt + 1;
        end
    end
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    debounce_min_a: assert property (
        $rose(flash_slot_power_o[0]) |-> low_cnt >= (DEBOUNCE_TICKS - 1) * TICK_DIV)
        else $error("slot powered before filter time");
    removal_off_a: assert property (flash_slot0_detect_n_i [*6] |=> !flash_slot_power_o[0])
        else $error("slot power stays after removal");
    pullup_sel_a: assert property (
        socket_inserted_i[1] && !socket_cardbus_i[1] |=> stschg_pullup_o[1] && !stschg_pulldown_o[1])
        else $error("no pullup for 16-bit card");
    pulldown_sel_a: assert property (
        socket_inserted_i[0] && socket_cardbus_i[0] |=> stschg_pulldown_o[0] && !stschg_pullup_o[0])
        else $error("no pulldown for cardbus card");
    led_valid_a: assert property (!socket_inserted_i[0] |=> !socket_a_activity_led_o)
        else $error("indicator on with empty socket");
    led_cut_a: assert property (suspend_i [*3] |=> !any_socket_activity_led_o)
        else $error("indicator on during suspend");
endmodule
bind shk_socket_housekeeping shk_housekeeping_chk #(.TICK_DIV(TICK_DIV), .DEBOUNCE_TICKS(DEBOUNCE_TICKS)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_slot0_detect_n_i(flash_slot0_detect_n_i), .suspend_i(suspend_i),
    .socket_inserted_i(socket_inserted_i), .socket_cardbus_i(socket_cardbus_i),
    .flash_slot_power_o(flash_slot_power_o), .stschg_pullup_o(stschg_pullup_o),
    .stschg_pulldown_o(stschg_pulldown_o), .socket_a_activity_led_o(socket_a_activity_led_o),
    .any_socket_activity_led_o(any_socket_activity_led_o)
);

// file: tb/shk_switch_model.sv
// behavioural model of the external socket power switch
`timescale 1ns/100ps
module shk_switch_model (
    input wire logic [10:0] ctrl_i,
    input wire logic type_sel_i,
    output logic [63:0] mv_o
);
    // supply level in millivolts, ffff while floating
    function automatic logic [15:0] vcc(input logic [1:0] c);
        if (!ctrl_i[8]) return 16'hffff;
        return c == 2'h1 ? 16'h0ce4 : (c == 2'h2 ? 16'h1388 : 16'h0000);
    endfunction
    // programming level, triplet order as on the wire
    function automatic logic [15:0] vpp(input logic [2:0] p);
        if (!ctrl_i[8] || (p[2] && p[1] && type_sel_i)) return 16'hffff;
        if (!p[2]) return p[1] ? (p[0] ? 16'h1388 : 16'h0ce4) : 16'h0000;
        if (type_sel_i) return 16'h2ee0;
        return p[1] && p[0] ? 16'h0708 : 16'hffff;
    endfunction
    // outputs: socket A supply, A prog, B supply, B prog
    always_comb begin
        mv_o = {vcc({ctrl_i[3], ctrl_i[2]}), vpp({ctrl_i[0], ctrl_i[1], ctrl_i[9]}),
                vcc({ctrl_i[6], ctrl_i[7]}), vpp({ctrl_i[4], ctrl_i[5], ctrl_i[10]})};
    end
endmodule

// file: tb/tb_top.sv
// self-checking bench of the socket housekeeping block
`timescale 1ns/100ps
module tb_top;
    // shortened tick, filter and indicator counts
    localparam int TD = 4;
    localparam int DT = 5;
    localparam int LT = 6;
    // table row: switch type, control fields, expected millivolts
    typedef struct packed {
        logic t;
        logic sd;
        logic [1:0] ca;
        logic [2:0] pa;
        logic [1:0] cb;
        logic [2:0] pb;
        logic [63:0] mv;
    } shk_row_t;
    shk_row_t rows [7] = '{
        '{1'b0, 1'b1, 2'h1, 3'h3, 2'h2, 3'h1, 64'h0ce4_0708_1388_0ce4},
        '{1'b0, 1'b1, 2'h2, 3'h2, 2'h3, 3'h4, 64'h1388_1388_0000_ffff},
        '{1'b0, 1'b1, 2'h0, 3'h5, 2'h1, 3'h0, 64'h0000_ffff_0ce4_0000},
        '{1'b1, 1'b1, 2'h3, 3'h3, 2'h0, 3'h6, 64'h0000_2ee0_0000_ffff},
        '{1'b1, 1'b1, 2'h1, 3'h1, 2'h2, 3'h2, 64'h0ce4_0ce4_1388_1388},
        '{1'b1, 1'b1, 2'h0, 3'h7, 2'h1, 3'h3, 64'h0000_ffff_0ce4_2ee0},
        '{1'b0, 1'b0, 2'h1, 3'h1, 2'h1, 3'h1, 64'hffff_ffff_ffff_ffff}};
    logic [2:0] aud [3] = '{3'h0, 3'h2, 3'h6};
    logic [1:0] aexp [3] = '{2'h0, 2'h2, 2'h1};
    logic clk_i, rst_i, cyc, stb, we, susp, ckstop, tsel;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic ack, spko, pwmo, led_a, led_b, led_any;
    logic [1:0] det_n, rdy_n, frm_n, irdy_n, req_n, spk, ins, pwr, irst, cbus, lowc, fpow, pu, pd;
    logic [10:0] sw;
    logic [63:0] mv;
    int error_cnt, checked;
    shk_socket_housekeeping #(.TICK_DIV(TD), .DEBOUNCE_TICKS(DT), .LED_TICKS(LT)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .flash_slot0_detect_n_i(det_n[0]), .flash_slot1_detect_n_i(det_n[1]), .card_ready_irq_n_i(rdy_n),
        .cb_frame_n_i(frm_n), .cb_irdy_n_i(irdy_n), .cb_req_n_i(req_n), .card_speaker_in_i(spk),
        .suspend_i(susp), .clkrun_stop_i(ckstop), .socket_inserted_i(ins), .socket_powered_i(pwr),
        .socket_in_reset_i(irst), .socket_cardbus_i(cbus), .socket_low_core_i(lowc),
        .switch_ctrl_o(sw), .flash_slot_power_o(fpow), .stschg_pullup_o(pu), .stschg_pulldown_o(pd),
        .speaker_out_o(spko), .audio_pwm_out_o(pwmo), .socket_a_activity_led_o(led_a),
        .socket_b_activity_led_o(led_b), .any_socket_activity_led_o(led_any));
    shk_switch_model sw_u (.ctrl_i(sw), .type_sel_i(tsel), .mv_o(mv));
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // compare and count
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // settle to sampling points between edges
    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // one classic bus cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask
    // one-cycle activity strobe: 0..2 bus strobes, 3 ready
    task automatic act(input int k, input int s);
        @(posedge clk_i);
        case (k)
            0: frm_n[s] <= 1'b0;
            1: irdy_n[s] <= 1'b0;
            2: req_n[s] <= 1'b0;
            default: rdy_n[s] <= 1'b0;
        endcase
        @(posedge clk_i);
        {frm_n, irdy_n, req_n, rdy_n} <= 8'hff;
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("errors %0d, checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
    initial begin
        {cyc, stb, we, susp, ckstop, tsel, adr, wdat} = '0;
        {det_n, rdy_n, frm_n, irdy_n, req_n} = 10'h3ff;
        {spk, ins, pwr, irst, cbus, lowc} = '0;
        {error_cnt, checked} = '0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc_n(1);
        chk({sw, fpow, led_any}, 0);
        wb(1'b0, 8'h24, 0);
        chk(q[10], 1'b0);
        wb(1'b0, 8'h14, 0);
        chk(q, 0);
        // switch encodings for both variants
        foreach (rows[i]) begin
            tsel = rows[i].t;
            wb(1'b1, 8'h24, {21'h0, rows[i].t, 10'h0});
            wb(1'b1, 8'h10, {21'h0, rows[i].sd, rows[i].pb, rows[i].cb, rows[i].pa, rows[i].ca});
            cyc_n(2);
            chk(mv, rows[i].mv);
        end
        // flash slots: bounce, insertion, removal
        wb(1'b1, 8'h10, 32'h1c00);
        for (int i = 0; i < 2; i++) begin
            act(4, 0);
            det_n[i] <= 1'b0;
            cyc_n(16);
            @(posedge clk_i);
            det_n[i] <= 1'b1;
            @(posedge clk_i);
            det_n[i] <= 1'b0;
            cyc_n(24);
            chk(fpow[i], 1'b0);
            cyc_n(60);
            chk(fpow[i], 1'b1);
            wb(1'b0, 8'h08, 0);
            chk({q[i], q[2+2*i +: 2]}, 3'h6);
            @(posedge clk_i);
            det_n[i] <= 1'b1;
            cyc_n(7);
            chk(fpow[i], 1'b0);
            wb(1'b0, 8'h08, 0);
            chk(q[5:0], 6'h0);
        end
        wb(1'b0, 8'h00, 0);
        chk(q, 3);
        // socket A cardbus, B 16-bit, both live
        @(posedge clk_i);
        {ins, pwr, cbus, lowc, spk} <= 10'h3d5;
        cyc_n(2);
        chk({pu, pd}, 4'h9);
        wb(1'b1, 8'h24, 0);
        wb(1'b0, 8'h08, 0);
        chk(q[7:6], 2'h1);
        wb(1'b1, 8'h24, 32'h400);
        wb(1'b0, 8'h08, 0);
        chk(q[7:6], 2'h2);
        for (int k = 0; k < 3; k++) begin
            act(k, 0);
            cyc_n(5);
            chk({led_a, led_b, led_any}, 3'h5);
            cyc_n(15);
            chk(led_a, 1'b1);
            cyc_n(20);
            chk(led_any, 1'b0);
        end
        repeat (6) begin
            act(0, 0);
            cyc_n(13);
            chk(led_a, 1'b1);
        end
        act(3, 1);
        cyc_n(5);
        chk({led_b, led_any}, 2'h3);
        // each cut blocks both indicators
        for (int k = 0; k < 5; k++) begin
            cyc_n(40);
            @(posedge clk_i);
            susp <= (k == 0);
            ckstop <= (k == 1);
            irst <= (k == 4) ? 2'h3 : 2'h0;
            wb(1'b1, 8'h20, (k == 2 || k == 3) ? 32'(k - 1) : 0);
            cyc_n(3);
            act(0, 0);
            act(3, 1);
            cyc_n(6);
            chk({led_a, led_b, led_any}, 3'h0);
            @(posedge clk_i);
            {susp, ckstop, irst} <= 4'h0;
            wb(1'b1, 8'h20, 0);
        end
        // audio steering per control setting
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, 8'h28, {29'h0, aud[k]});
            cyc_n(5);
            chk({spko, pwmo}, aexp[k]);
        end
        test_done();
    end
endmodule
